// *** inc/rs485_link_config_defines.vh ***
// constants for the rs-485 link configuration and supervision block
`ifndef RS485_LINK_CONFIG_DEFINES_VH
`define RS485_LINK_CONFIG_DEFINES_VH

// register byte addresses
`define ADDR_P1_CFG    8'h00
`define ADDR_P2_CFG    8'h04
`define ADDR_P1_TIM    8'h08
`define ADDR_P2_TIM    8'h0c
`define ADDR_INST      8'h10
`define ADDR_CTRL      8'h14
`define ADDR_IRQ_ST    8'h18
`define ADDR_IRQ_MASK  8'h1c
`define ADDR_INST_NUM  8'h20
`define ADDR_FRAME     8'h24

// port configuration fields
`define CFG_LEN        0
`define CFG_PAR        2:1
`define CFG_STOP       3
`define CFG_PROTO      11:4
`define CFG_ERRH       13:12
`define CFG_STN        23:16
`define CFG_MASK       32'h00ff3fff

// port timing fields
`define TIM_TOUT       5:0
`define TIM_REPLY      14:8
`define TIM_ERRT       25:16
`define TIM_MASK       32'h03ff7f3f

// instance and control fields
`define INST_UP        12:0
`define INST_LO        25:16
`define INST_MASK      32'h03ff1fff
`define CTRL_CLR       1:0
`define CTRL_STORE     3:2
`define CTRL_LOADER    5:4

// interrupt status bits
`define IRQ_ALARM      1:0
`define IRQ_TOUT       3:2
`define IRQ_SAVED      4
`define IRQ_CLEARED    5
`define IRQ_W          6

// reset values
`define REG_RST        32'h00000000
`define IRQ_RST        6'h00

// encodings
`define LEN_8BIT       1'b0
`define STOP_2BIT      1'b0
`define PAR_NONE       2'h0
`define PAR_EVEN       2'h1
`define PAR_ODD        2'h2
`define PROTO_MODBUS   8'h00
`define PROTO_LOADER   8'h01
`define PROTO_GENERAL  8'h02
`define PROTO_BUILDING 8'h03
`define PROTO_BACNET   8'h05
`define PROTO_MUTUAL   8'h32
`define ERRH_TRIP      2'h0
`define ERRH_DELAY     2'h1
`define ERRH_RETRY     2'h2
`define ERRH_CONT      2'h3
`define STORE_NV       2'h0
`define STORE_TEMP     2'h1
`define STORE_SAVE     2'h2
`define CLR_FREQ_BIT   0
`define CLR_RUN_BIT    1

// timing: one tick is 10 ms
`define TICK_DEFAULT   21'd1250000
`define TICKS_PER_S    13'd100
`define TICKS_PER_DS   13'd10

// device instance arithmetic
`define INST_MULT      23'd1000
`define INST_MAX       22'd4194302
`define INST_LO_MIN    10'd128

`endif

// *** core/rs485_link_config.v ***
// rs-485 link configuration, supervision, alarm clearing and command source selection
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rs485_link_config_defines.vh"

module rs485_link_config #(
  // cycles per 10 ms tick at the default clock; a bench may shrink it
  parameter [20:0] TICK_CYCLES = `TICK_DEFAULT
) (
  input  wire        clk,
  input  wire        reset,
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  input  wire [1:0]  rx_request,
  input  wire [1:0]  host_access,
  input  wire [1:0]  comm_error,
  input  wire [1:0]  link_cmd_active,
  input  wire        bus_option_alarm,
  input  wire        alarm_reset,
  input  wire        save_all_done,
  output wire [1:0]  data_bits8,
  output wire [3:0]  parity_mode,
  output wire [1:0]  two_stop,
  output wire [1:0]  protocol_ok,
  output wire [1:0]  reply_go,
  output wire [1:0]  comm_alarm,
  output reg         clear_freq_refs,
  output reg         clear_run_bits,
  output reg         nv_write,
  output reg         save_all_start,
  output reg         loader_freq_src,
  output reg         loader_run_src,
  output reg  [21:0] instance_num,
  output reg         irq
);

  reg  [31:0] cfg_q [0:1];
  reg  [31:0] tim_q [0:1];
  reg  [31:0] inst_q;
  reg  [1:0]  clr_sel_q;
  reg  [1:0]  store_q;
  reg  [1:0]  loader_q;
  reg  [5:0]  irq_st_q;
  reg  [5:0]  irq_mask_q;
  reg  [20:0] tick_cnt_q;
  reg         tick_q;
  wire [1:0]  alarm_rise;
  wire [1:0]  tout_fire;
  wire [7:0]  frame_st;

  // shared 10 ms tick; supervision timers tolerate one tick of slack
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tick_cnt_q <= 21'h000000;
      tick_q     <= 1'b0;
    end
    else if (tick_cnt_q == TICK_CYCLES - 21'h000001)
    begin
      tick_cnt_q <= 21'h000000;
      tick_q     <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 21'h000001;
      tick_q     <= 1'b0;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_port
      wire [7:0]  proto     = cfg_q[i][`CFG_PROTO];
      wire [1:0]  psel      = cfg_q[i][`CFG_PAR];
      wire        is_modbus = (proto == `PROTO_MODBUS);
      wire        is_loader = (proto == `PROTO_LOADER);
      wire [12:0] tout_lim  = {7'h00, tim_q[i][`TIM_TOUT]} * `TICKS_PER_S;
      wire [12:0] errt_lim  = {3'h0, tim_q[i][`TIM_ERRT]} * `TICKS_PER_DS;
      wire        tout_on   = link_cmd_active[i] && (tim_q[i][`TIM_TOUT] != 6'h00);
      wire [1:0]  errh      = cfg_q[i][`CFG_ERRH];
      reg         data8_q;
      reg  [1:0]  par_q;
      reg         stop2_q;
      reg         pok_q;
      reg         reply_busy_q;
      reg  [6:0]  reply_cnt_q;
      reg  [20:0] reply_sub_q;
      reg         reply_q;
      reg  [12:0] tout_cnt_q;
      reg         tout_done_q;
      reg         err_busy_q;
      reg         err_retry_q;
      reg  [12:0] err_cnt_q;
      reg         alarm_q;
      reg         alarm_set;
      wire        tout_hit;
      wire        err_ev;

      // fires once per silence; the done flag holds until access or drop-out
      assign tout_hit = tout_on && tick_q && !tout_done_q
                        && (tout_cnt_q + 13'h0001 >= tout_lim);
      assign err_ev   = link_cmd_active[i] && (comm_error[i] || tout_hit);

      always @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          data8_q <= 1'b1;
          par_q   <= `PAR_NONE;
          stop2_q <= 1'b1;
          pok_q   <= 1'b1;
        end
        else
        begin
          data8_q <= is_modbus || is_loader || (cfg_q[i][`CFG_LEN] == `LEN_8BIT);
          if (is_loader)
            par_q <= `PAR_EVEN;
          else if (psel == `PAR_EVEN || psel == `PAR_ODD)
            par_q <= psel;
          else
            par_q <= `PAR_NONE;
          if (is_loader)
            stop2_q <= 1'b0;
          else if (is_modbus)
            stop2_q <= (psel == `PAR_NONE);
          else
            stop2_q <= (cfg_q[i][`CFG_STOP] == `STOP_2BIT);
          // code 50 is refused on port one, yet its frame is still derived
          pok_q <= is_modbus || is_loader || proto == `PROTO_GENERAL
                   || proto == `PROTO_BUILDING || proto == `PROTO_BACNET
                   || (proto == `PROTO_MUTUAL && i == 1);
        end
      end

      // exact per-port cycle count so the reply never comes early
      always @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          reply_busy_q <= 1'b0;
          reply_cnt_q  <= 7'h00;
          reply_sub_q  <= 21'h000000;
          reply_q      <= 1'b0;
        end
        else
        begin
          reply_q <= 1'b0;
          if (rx_request[i])
          begin
            reply_busy_q <= 1'b1;
            reply_cnt_q  <= tim_q[i][`TIM_REPLY];
            reply_sub_q  <= TICK_CYCLES - 21'h000001;
          end
          else if (reply_busy_q)
          begin
            if (reply_cnt_q == 7'h00)
            begin
              reply_busy_q <= 1'b0;
              reply_q      <= 1'b1;
            end
            else if (reply_sub_q == 21'h000000)
            begin
              reply_cnt_q <= reply_cnt_q - 7'h01;
              reply_sub_q <= TICK_CYCLES - 21'h000001;
            end
            else
              reply_sub_q <= reply_sub_q - 21'h000001;
          end
        end
      end

      always @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          tout_cnt_q  <= 13'h0000;
          tout_done_q <= 1'b0;
        end
        else if (!tout_on || host_access[i])
        begin
          tout_cnt_q  <= 13'h0000;
          tout_done_q <= 1'b0;
        end
        else if (tout_hit)
          tout_done_q <= 1'b1;
        else if (tick_q && !tout_done_q)
          tout_cnt_q <= tout_cnt_q + 13'h0001;
      end

      always @*
      begin
        alarm_set = 1'b0;
        if (err_ev && errh == `ERRH_TRIP)
          alarm_set = 1'b1;
        if (err_busy_q && !(err_retry_q && host_access[i]) && err_cnt_q == 13'h0000)
          alarm_set = 1'b1;
      end

      always @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          err_busy_q  <= 1'b0;
          err_retry_q <= 1'b0;
          err_cnt_q   <= 13'h0000;
          alarm_q     <= 1'b0;
        end
        else
        begin
          // a retry that sees valid host access ends without an alarm
          if (err_busy_q)
          begin
            if ((err_retry_q && host_access[i]) || err_cnt_q == 13'h0000)
              err_busy_q <= 1'b0;
            else if (tick_q)
              err_cnt_q <= err_cnt_q - 13'h0001;
          end
          else if (err_ev && (errh == `ERRH_DELAY || errh == `ERRH_RETRY))
          begin
            err_busy_q  <= 1'b1;
            err_retry_q <= (errh == `ERRH_RETRY);
            err_cnt_q   <= errt_lim;
          end
          // a new alarm outranks a reset in the same cycle
          if (alarm_set)
            alarm_q <= 1'b1;
          else if (alarm_reset)
            alarm_q <= 1'b0;
        end
      end

      assign data_bits8[i]          = data8_q;
      assign parity_mode[2*i+1:2*i] = par_q;
      assign two_stop[i]            = stop2_q;
      assign protocol_ok[i]         = pok_q;
      assign reply_go[i]            = reply_q;
      assign comm_alarm[i]          = alarm_q;
      assign alarm_rise[i]          = alarm_set && !alarm_q;
      assign tout_fire[i]           = tout_hit;
      assign frame_st[4*i+3:4*i]    = {stop2_q, par_q, data8_q};
    end
  endgenerate

  // instance number: station address of port one if it runs bacnet, else of port two
  // lower 1 to 127 falls back to the station address, as 0 does
  wire        bac_p1   = (cfg_q[0][`CFG_PROTO] == `PROTO_BACNET);
  wire [7:0]  bac_stn  = bac_p1 ? cfg_q[0][`CFG_STN] : cfg_q[1][`CFG_STN];
  wire [9:0]  inst_lo  = inst_q[`INST_LO];
  wire [9:0]  inst_add = (inst_lo >= `INST_LO_MIN) ? inst_lo : {2'b00, bac_stn};
  wire [22:0] inst_sum = {10'h000, inst_q[`INST_UP]} * `INST_MULT + {13'h0000, inst_add};
  wire        any_alarm = (|alarm_rise) || bus_option_alarm;
  wire        wr_store = wr && addr == `ADDR_CTRL;
  wire        saved_ev = (store_q == `STORE_SAVE) && save_all_done;
  wire [5:0]  irq_set  = {any_alarm && clr_sel_q != 2'h0, saved_ev, tout_fire, alarm_rise};
  wire [5:0]  irq_clr  = (wr && addr == `ADDR_IRQ_ST) ? wdata[5:0] : 6'h00;
  wire [5:0]  irq_st_d = (irq_st_q & ~irq_clr) | irq_set;

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cfg_q[0]        <= `REG_RST;
      cfg_q[1]        <= `REG_RST;
      tim_q[0]        <= `REG_RST;
      tim_q[1]        <= `REG_RST;
      inst_q          <= `REG_RST;
      clr_sel_q       <= 2'h0;
      store_q         <= `STORE_NV;
      loader_q        <= 2'h0;
      irq_st_q        <= `IRQ_RST;
      irq_mask_q      <= `IRQ_RST;
      rdata           <= `REG_RST;
      clear_freq_refs <= 1'b0;
      clear_run_bits  <= 1'b0;
      nv_write        <= 1'b1;
      save_all_start  <= 1'b0;
      loader_freq_src <= 1'b0;
      loader_run_src  <= 1'b0;
      instance_num    <= 22'h000000;
      irq             <= 1'b0;
    end
    else
    begin
      if (wr && addr == `ADDR_P1_CFG)
        cfg_q[0] <= wdata & `CFG_MASK;
      else if (wr && addr == `ADDR_P2_CFG)
        cfg_q[1] <= wdata & `CFG_MASK;
      else if (wr && addr == `ADDR_P1_TIM)
        tim_q[0] <= wdata & `TIM_MASK;
      else if (wr && addr == `ADDR_P2_TIM)
        tim_q[1] <= wdata & `TIM_MASK;
      else if (wr && addr == `ADDR_INST)
        inst_q <= wdata & `INST_MASK;
      else if (wr && addr == `ADDR_IRQ_MASK)
        irq_mask_q <= wdata[5:0];
      if (wr_store)
      begin
        clr_sel_q <= wdata[`CTRL_CLR];
        loader_q  <= wdata[`CTRL_LOADER];
      end
      // a save in progress cannot be overwritten; selector 3 is ignored
      if (saved_ev)
        store_q <= `STORE_TEMP;
      else if (wr_store && store_q != `STORE_SAVE && wdata[`CTRL_STORE] != 2'h3)
        store_q <= wdata[`CTRL_STORE];
      save_all_start  <= wr_store && store_q != `STORE_SAVE
                         && wdata[`CTRL_STORE] == `STORE_SAVE;
      // nv_write follows the selector one cycle late
      nv_write        <= (store_q == `STORE_NV);
      clear_freq_refs <= any_alarm && clr_sel_q[`CLR_FREQ_BIT];
      clear_run_bits  <= any_alarm && clr_sel_q[`CLR_RUN_BIT];
      loader_freq_src <= loader_q[0];
      loader_run_src  <= loader_q[1];
      if (inst_sum > {1'b0, `INST_MAX})
        instance_num <= `INST_MAX;
      else
        instance_num <= inst_sum[21:0];
      irq_st_q <= irq_st_d;
      irq      <= |(irq_st_d & irq_mask_q);
      // read data stand one cycle, zero otherwise, so a stale word never lingers
      if (!rd)
        rdata <= `REG_RST;
      else if (addr == `ADDR_P1_CFG)
        rdata <= cfg_q[0];
      else if (addr == `ADDR_P2_CFG)
        rdata <= cfg_q[1];
      else if (addr == `ADDR_P1_TIM)
        rdata <= tim_q[0];
      else if (addr == `ADDR_P2_TIM)
        rdata <= tim_q[1];
      else if (addr == `ADDR_INST)
        rdata <= inst_q;
      else if (addr == `ADDR_CTRL)
        rdata <= {26'h0000000, loader_q, store_q, clr_sel_q};
      else if (addr == `ADDR_IRQ_ST)
        rdata <= {26'h0000000, irq_st_q};
      else if (addr == `ADDR_IRQ_MASK)
        rdata <= {26'h0000000, irq_mask_q};
      else if (addr == `ADDR_INST_NUM)
        rdata <= {10'h000, instance_num};
      else if (addr == `ADDR_FRAME)
        rdata <= {20'h00000, comm_alarm, protocol_ok, frame_st};
      else
        rdata <= `REG_RST;
    end
  end

endmodule
`default_nettype wire

// *** dv/rs485_link_config_sva.sv ***
// assertion checker for the link configuration block
`timescale 1ns/1ps
`default_nettype none
module rs485_link_config_sva (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic [1:0]  rx_request,
  input wire logic [1:0]  link_cmd_active,
  input wire logic [1:0]  reply_go,
  input wire logic [1:0]  comm_alarm,
  input wire logic        clear_freq_refs,
  input wire logic        save_all_start,
  input wire logic        loader_freq_src,
  input wire logic        loader_run_src,
  input wire logic [21:0] instance_num
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_ctrl_wr;
    wr && addr == 8'h14;
  endsequence
  sequence s_save_req;
    s_ctrl_wr ##0 wdata[3:2] == 2'h2;
  endsequence
  property p_reply_gap;
    (rx_request != 2'h0) |=> (reply_go & $past(rx_request)) == 2'h0;
  endproperty
  a_reply_gap: assert property (p_reply_gap)
    else $error("reply in the cycle after its request");
  property p_save_go;
    s_save_req |-> ##[1:2] save_all_start;
  endproperty
  a_save_go: assert property (p_save_go)
    else $error("save all did not start");
  property p_save_pulse;
    save_all_start |=> !save_all_start;
  endproperty
  a_save_pulse: assert property (p_save_pulse)
    else $error("save start longer than one cycle");
  property p_loader_cause;
    $changed({loader_freq_src, loader_run_src}) |->
      $past(wr && addr == 8'h14) || $past(wr && addr == 8'h14, 2);
  endproperty
  a_loader_cause: assert property (p_loader_cause)
    else $error("loader source changed without a control write");
  property p_loader_reset;
    $past(reset) |-> !loader_freq_src && !loader_run_src;
  endproperty
  a_loader_reset: assert property (p_loader_reset)
    else $error("loader source not zero after reset");
  property p_inst_max;
    instance_num <= 22'd4194302;
  endproperty
  a_inst_max: assert property (p_inst_max)
    else $error("instance number above limit");
  property p_alarm_link;
    $rose(comm_alarm[0]) |-> $past(link_cmd_active[0]);
  endproperty
  a_alarm_link: assert property (p_alarm_link)
    else $error("alarm raised without link command");
  property p_clear_pulse;
    clear_freq_refs |=> !clear_freq_refs;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse)
    else $error("reference clear longer than one cycle");
endmodule
`default_nettype wire

// *** dv/host_model.sv ***
// host model: issues one request at a time and times the reply
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       sel,
  input  wire logic [1:0] reply_go,
  output var logic  [1:0] rx_request,
  output var logic        busy,
  output var int          lat
);
  int cnt;
  initial
  begin
    rx_request = 2'h0;
    busy = 1'b0;
    lat = 0;
    cnt = 0;
  end
  // half duplex is left to the caller: a go while busy sends a new request and restarts the timing
  always @(posedge clk)
  begin
    rx_request <= go ? (2'h1 << sel) : 2'h0;
    if (go)
    begin
      busy <= 1'b1;
      cnt <= -1;
    end
    else if (busy)
    begin
      cnt <= cnt + 1;
      if (reply_go[sel] && cnt >= 0)
      begin
        lat <= cnt + 1;
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/rs485_link_config_test.sv ***
// testbench for the link configuration block
`timescale 1ns/1ps
`default_nettype none
module rs485_link_config_test;
  logic        clk, reset, wr, rd, go, sel, bus_option_alarm, alarm_reset, save_all_done;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  rx_request, host_access, comm_error, link_cmd_active;
  logic [1:0]  data_bits8, two_stop, protocol_ok, reply_go, comm_alarm;
  logic [3:0]  parity_mode;
  logic        clear_freq_refs, clear_run_bits, nv_write, save_all_start, busy, irq;
  logic        loader_freq_src, loader_run_src;
  logic [21:0] instance_num;
  int          lat, mismatches, comparisons, cycles;
  // short tick keeps second-scale counts inside the run
  rs485_link_config #(.TICK_CYCLES(21'd4)) rs485_link_config_inst (.clk, .reset, .addr,
    .wdata, .wr, .rd, .rdata, .rx_request, .host_access, .comm_error, .link_cmd_active,
    .bus_option_alarm, .alarm_reset, .save_all_done, .data_bits8, .parity_mode, .two_stop,
    .protocol_ok, .reply_go, .comm_alarm, .clear_freq_refs, .clear_run_bits, .nv_write,
    .save_all_start, .loader_freq_src, .loader_run_src, .instance_num, .irq);
  host_model host_model_inst (.clk, .go, .sel, .reply_go, .rx_request, .busy, .lat);
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task rd_reg(input logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
    @(posedge clk);
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task t_regs;
    rd_reg(8'h14);
    chk("ctrl reset", v, 32'h0);
    wr_reg(8'h28, 32'hffffffff);
    rd_reg(8'h28);
    chk("unmapped", v, 32'h0);
    wr_reg(8'h00, 32'hffffffff);
    rd_reg(8'h00);
    chk("cfg mask", v, 32'h00ff3fff);
  endtask
  task frame(input logic p, input logic [11:0] c, input logic [4:0] e);
    wr_reg(p ? 8'h04 : 8'h00, {20'h0, c});
    wait_n(2);
    chk("frame", {protocol_ok[p], two_stop[p], parity_mode[2*p+:2], data_bits8[p]}, e);
  endtask
  task reply(input logic p, input logic [6:0] d, input int e);
    int i;
    wr_reg(p ? 8'h0c : 8'h08, {17'h0, d, 8'h00});
    sel <= p;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 1000 && busy; i++)
      @(posedge clk);
    chk("reply latency", lat, e);
  endtask
  task inst(input logic [31:0] w, input logic [21:0] e);
    wr_reg(8'h10, w);
    wait_n(4);
    chk("instance", instance_num, e);
  endtask
  task clr(input logic [1:0] s);
    logic f, r;
    f = 1'b0;
    r = 1'b0;
    wr_reg(8'h14, {30'h0, s});
    bus_option_alarm <= 1'b1;
    @(posedge clk);
    bus_option_alarm <= 1'b0;
    repeat (4)
    begin
      #1;
      f |= clear_freq_refs;
      r |= clear_run_bits;
      @(posedge clk);
    end
    chk("clear", {f, r}, {s[0], s[1]});
  endtask
  task t_irq;
    logic a;
    wr_reg(8'h1c, 32'h0);
    wait_n(2);
    a = irq;
    wr_reg(8'h1c, 32'h3f);
    wait_n(2);
    chk("irq mask", {a, irq}, 2'b01);
    wr_reg(8'h18, 32'h3f);
    rd_reg(8'h18);
    chk("irq status", v, 32'h0);
    wait_n(1);
    chk("irq off", irq, 1'b0);
  endtask
  task err(input logic [1:0] m, input logic l, input logic acc, input logic e20, e60);
    wr_reg(8'h00, {18'h0, m, 8'h02, 4'h0});
    wr_reg(8'h08, 32'h00010000);
    link_cmd_active <= {1'b0, l};
    comm_error <= 2'h1;
    @(posedge clk);
    comm_error <= 2'h0;
    wait_n(5);
    host_access <= {1'b0, acc};
    wait_n(1);
    host_access <= 2'h0;
    wait_n(14);
    chk("alarm early", comm_alarm[0], e20);
    wait_n(40);
    chk("alarm late", comm_alarm[0], e60);
    alarm_reset <= 1'b1;
    @(posedge clk);
    alarm_reset <= 1'b0;
    wait_n(2);
  endtask
  task tout;
    wr_reg(8'h00, 32'h00003020);
    wr_reg(8'h18, 32'h3f);
    wr_reg(8'h08, 32'h1);
    link_cmd_active <= 2'h1;
    wait_n(380);
    rd_reg(8'h18);
    chk("no timeout yet", v[2], 1'b0);
    wait_n(30);
    rd_reg(8'h18);
    chk("timeout", v[2], 1'b1);
    wr_reg(8'h18, 32'h4);
    wait_n(300);
    host_access <= 2'h1;
    @(posedge clk);
    host_access <= 2'h0;
    wait_n(200);
    rd_reg(8'h18);
    chk("access restarts", v[2], 1'b0);
    wait_n(220);
    rd_reg(8'h18);
    chk("timeout again", v[2], 1'b1);
    wr_reg(8'h08, 32'h0);
    wr_reg(8'h18, 32'h3f);
    wait_n(500);
    rd_reg(8'h18);
    chk("timeout off", v[2], 1'b0);
    link_cmd_active <= 2'h0;
  endtask
  task store;
    wr_reg(8'h14, 32'h4);
    wait_n(2);
    chk("temp store", nv_write, 1'b0);
    wr_reg(8'h14, 32'h0);
    wait_n(2);
    chk("nv store", nv_write, 1'b1);
    wr_reg(8'h14, 32'h8);
    rd_reg(8'h14);
    chk("saving", v[3:2], 2'h2);
    save_all_done <= 1'b1;
    @(posedge clk);
    save_all_done <= 1'b0;
    wr_reg(8'h14, 32'hc);
    rd_reg(8'h14);
    chk("saved", v[3:2], 2'h1);
  endtask
  task loader;
    int i;
    for (i = 0; i < 4; i++)
    begin
      wr_reg(8'h14, i << 4);
      wait_n(2);
      chk("loader src", {loader_freq_src, loader_run_src}, {i[0], i[1]});
    end
    reset <= 1'b1;
    wait_n(2);
    reset <= 1'b0;
    wait_n(1);
    rd_reg(8'h14);
    chk("loader after reset", {v[5:4], loader_freq_src, loader_run_src}, 4'h0);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    cycles = 0;
    forever
    begin
      @(posedge clk);
      cycles++;
      if (cycles > 20000)
      begin
        mismatches++;
        give_verdict;
      end
    end
  end
  initial
  begin
    {reset, wr, rd, go, sel, bus_option_alarm, alarm_reset, save_all_done} = 8'h80;
    {addr, wdata, host_access, comm_error, link_cmd_active} = 46'h0;
    mismatches = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs;
    frame(0, 12'h02d, 5'h14);
    frame(0, 12'h026, 5'h19);
    frame(0, 12'h02a, 5'h13);
    frame(0, 12'h009, 5'h19);
    frame(0, 12'h007, 5'h11);
    frame(0, 12'h015, 5'h13);
    frame(0, 12'h039, 5'h10);
    frame(0, 12'h050, 5'h19);
    frame(0, 12'h320, 5'h09);
    frame(1, 12'h320, 5'h19);
    frame(1, 12'h040, 5'h09);
    reply(0, 7'd0, 2);
    reply(0, 7'd1, 6);
    reply(1, 7'd3, 14);
    reply(0, 7'd100, 402);
    wr_reg(8'h00, 32'h00150050);
    inst(32'h00000002, 22'd2021);
    inst(32'h01f40002, 22'd2500);
    inst(32'h03e71fff, 22'd4194302);
    for (int s = 0; s < 4; s++)
      clr(s[1:0]);
    t_irq;
    err(2'h0, 1, 0, 1, 1);
    err(2'h1, 1, 0, 0, 1);
    err(2'h2, 1, 1, 0, 0);
    err(2'h2, 1, 0, 0, 1);
    err(2'h3, 1, 0, 0, 0);
    err(2'h0, 0, 0, 0, 0);
    tout;
    store;
    loader;
    give_verdict;
  end
endmodule
bind rs485_link_config rs485_link_config_sva rs485_link_config_sva_inst (.clk, .reset, .addr,
  .wdata, .wr, .rx_request, .link_cmd_active, .reply_go, .comm_alarm, .clear_freq_refs,
  .save_all_start, .loader_freq_src, .loader_run_src, .instance_num);
`default_nettype wire
